// ===== hw/ssc_map.svh
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH

// ==========================================================
// widths
`define SSC_ADDR_W 18
`define SSC_DATA_W 16
`define SSC_LANES 2
`define SSC_BURST_W 2
`define SSC_FIFO_DEPTH 32

// ==========================================================
// reset values
`define SSC_MODE_RST 1'b1
`define SSC_BURST_RST 2'h0

`endif

// ===== hw/ssc_pkg.sv
`include "ssc_map.svh"

package ssc_pkg;

    // ==========================================================
    // types shared by the controller and its write queue

    // operation held in the address stage
    typedef enum logic [1:0] {
        SSC_OP_IDLE,
        SSC_OP_READ,
        SSC_OP_WRITE
    } ssc_op_t;

    // one queued write: word, parity and lane enables
    typedef struct packed {
        logic [`SSC_ADDR_W-1:0] addr;
        logic [`SSC_DATA_W-1:0] data;
        logic [`SSC_LANES-1:0] parity;
        logic [`SSC_LANES-1:0] lane_en;
    } ssc_wr_t;

endpackage : ssc_pkg

// ===== hw/ssc_sram_ctrl.sv
`timescale 1ns/1ns
`include "ssc_map.svh"

// ==========================================================
// write queue: parameterised synchronous fifo
module ssc_fifo #(
    parameter int WIDTH = 38,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [PW:0] count_q;
    logic push;
    logic pop;

    // honest flags straight from the occupancy count
    assign in_ready = (count_q != DEPTH[PW:0]);
    assign out_valid = (count_q != '0);
    assign out_data = store[rd_ptr_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // storage has no reset; only the pointers matter
    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            store[wr_ptr_q] <= in_data;
        end
    end

    // pointers wrap naturally since depth is a power of two
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push && !pop)
            begin
                count_q <= count_q + 1'b1;
            end
            else if (pop && !push)
            begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule : ssc_fifo

// ==========================================================
// pipelined synchronous burst memory, device side
//
// edge N with go takes a load or an advance into the address stage;
// edge N+1 fetches a read into the output register and turns the
// drivers on, or opens a write data phase with the drivers off;
// edge N+2 captures the write data pins into the write queue.
// a negated qualifier or a full queue freezes every stage at once,
// so the controller sees a stretched cycle, never a lost select.
// the queue lets a write and a read share one array port: reads
// win, and a queued word drains on the next edge without a fetch.
// limitation: a read of a word still waiting in the queue returns
// the older contents, so a controller that reads straight back
// what it has just written must leave one edge without a read.
module ssc_sram_ctrl (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // chip selects and cycle qualifier
    input wire logic chip_select_a_n,
    input wire logic chip_select_b,
    input wire logic chip_select_c_n,
    input wire logic clock_qualify_n,
    // command and address
    input wire logic [`SSC_ADDR_W-1:0] address,
    input wire logic write_n,
    input wire logic advance_or_load,
    input wire logic [`SSC_LANES-1:0] byte_lane_write_n,
    // asynchronous output gate and burst strap
    input wire logic output_gate_n,
    input wire logic burst_mode_strap,
    // data and parity pins, split into in/out/enable
    input wire logic [`SSC_DATA_W-1:0] data_in,
    output logic [`SSC_DATA_W-1:0] data_out,
    input wire logic [`SSC_LANES-1:0] parity_lines_in,
    output logic [`SSC_LANES-1:0] parity_lines_out,
    output logic data_oe_n,
    // internal stall: write queue full
    output logic queue_full_q
);
    localparam int WR_W = $bits(ssc_pkg::ssc_wr_t);
    localparam int WORDS = 2 ** `SSC_ADDR_W;
    localparam int CELL_W = `SSC_DATA_W + `SSC_LANES;

    // byte lanes merge; used for both data and parity halves
    function automatic logic [CELL_W-1:0] lane_merge(
        input logic [CELL_W-1:0] old_cell,
        input logic [CELL_W-1:0] new_cell,
        input logic [`SSC_LANES-1:0] lane_en
    );
        logic [CELL_W-1:0] res;
        res = old_cell;
        // low lane: data 7:0 and parity 0; high: data 15:8, parity 1
        if (lane_en[0])
        begin
            res[7:0] = new_cell[7:0];
            res[16] = new_cell[16];
        end
        if (lane_en[1])
        begin
            res[15:8] = new_cell[15:8];
            res[17] = new_cell[17];
        end
        return res;
    endfunction : lane_merge

    // burst beat address low bits; both orders wrap within four
    function automatic logic [`SSC_BURST_W-1:0] burst_low(
        input logic [`SSC_BURST_W-1:0] start,
        input logic [`SSC_BURST_W-1:0] beat,
        input logic interleave
    );
        logic [`SSC_BURST_W-1:0] res;
        if (interleave)
        begin
            // interleaved order flips address bits, never carries
            res = start ^ beat;
        end
        else
        begin
            // linear order counts up; the carry out is dropped on purpose
            res = start + beat;
        end
        return res;
    endfunction : burst_low

    // ==========================================================
    // storage and pipeline state
    logic [CELL_W-1:0] mem [0:WORDS-1];
    logic mode_meta_q;
    logic mode_q;
    ssc_pkg::ssc_op_t op_q;
    logic [`SSC_ADDR_W-1:0] base_q;
    logic [`SSC_BURST_W-1:0] burst_q;
    logic [`SSC_LANES-1:0] lane_en_q;
    logic wr_phase_q;
    logic [`SSC_ADDR_W-1:0] wr_addr_q;
    logic [`SSC_LANES-1:0] wr_lane_q;
    logic drive_q;
    logic [CELL_W-1:0] rd_cell_q;
    logic selected;
    logic go;
    logic [`SSC_ADDR_W-1:0] cur_addr;
    logic [`SSC_BURST_W-1:0] low_bits;
    ssc_pkg::ssc_wr_t push_word;
    ssc_pkg::ssc_wr_t head_word;
    logic q_in_ready;
    logic q_out_valid;
    logic q_out_ready;
    logic [WR_W-1:0] q_out_raw;

    // all three selects at their active levels
    assign selected = ~chip_select_a_n & chip_select_b & ~chip_select_c_n;

    // an edge counts only when qualified and the queue can take a word;
    // a full queue stalls exactly like a negated qualifier
    assign go = ~clock_qualify_n & q_in_ready;

    // burst address: interleave xors, linear adds, both wrap
    assign low_bits = burst_low(base_q[`SSC_BURST_W-1:0], burst_q, mode_q);
    assign cur_addr = {base_q[`SSC_ADDR_W-1:2], low_bits};

    // ==========================================================
    // burst strap: static pin, passes two flops; resets to
    // interleaved so an open strap reads high
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            mode_meta_q <= `SSC_MODE_RST;
            mode_q <= `SSC_MODE_RST;
        end
        else
        begin
            mode_meta_q <= burst_mode_strap;
            mode_q <= mode_meta_q;
        end
    end

    // ==========================================================
    // address stage: load, advance or deselect; frozen when not go
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            op_q <= ssc_pkg::SSC_OP_IDLE;
            base_q <= '0;
            burst_q <= `SSC_BURST_RST;
            lane_en_q <= '0;
        end
        else if (go) // otherwise hold, never deselect
        begin
            // byte selects are sampled every go edge, even within a burst
            lane_en_q <= ~byte_lane_write_n;
            if (advance_or_load)
            begin
                // advance regardless of selects; op type is kept
                burst_q <= burst_q + 1'b1;
            end
            else if (selected)
            begin
                base_q <= address;
                burst_q <= `SSC_BURST_RST;
                op_q <= write_n ? ssc_pkg::SSC_OP_READ
                                : ssc_pkg::SSC_OP_WRITE;
            end
            else
            begin
                op_q <= ssc_pkg::SSC_OP_IDLE;
            end
        end
    end

    // ==========================================================
    // second stage: read fetch, write data phase, drive control
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            wr_phase_q <= 1'b0;
            wr_addr_q <= '0;
            wr_lane_q <= '0;
            drive_q <= 1'b0;
        end
        else if (go)
        begin
            wr_phase_q <= (op_q == ssc_pkg::SSC_OP_WRITE);
            wr_addr_q <= cur_addr;
            wr_lane_q <= lane_en_q;
            // deselect or write ends drive one edge later
            drive_q <= (op_q == ssc_pkg::SSC_OP_READ);
        end
    end

    // read data registered one edge after its address
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            rd_cell_q <= '0;
        end
        else if (go && op_q == ssc_pkg::SSC_OP_READ)
        begin
            rd_cell_q <= mem[cur_addr];
        end
    end

    // ==========================================================
    // write queue: the captured pins form the data register
    assign push_word.addr = wr_addr_q;
    assign push_word.data = data_in;
    assign push_word.parity = parity_lines_in;
    assign push_word.lane_en = wr_lane_q;

    // the single array port belongs to a read when one is fetched,
    // so draining stalls then, though the queue never holds more than two words
    assign q_out_ready = ~(go && op_q == ssc_pkg::SSC_OP_READ);
    assign head_word = ssc_pkg::ssc_wr_t'(q_out_raw);

    ssc_fifo #(
        .WIDTH(WR_W),
        .DEPTH(`SSC_FIFO_DEPTH)
    ) u_wr_queue (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_valid(~clock_qualify_n & wr_phase_q),
        .in_ready(q_in_ready),
        .in_data(WR_W'(push_word)),
        .out_valid(q_out_valid),
        .out_ready(q_out_ready),
        .out_data(q_out_raw)
    );

    // commit queued words lane by lane; unselected lanes keep old data;
    // a read issued before its queued write drains sees the older word
    always_ff @(posedge clk_sys)
    begin
        if (q_out_valid && q_out_ready)
        begin
            mem[head_word.addr] <= lane_merge(mem[head_word.addr],
                {head_word.parity, head_word.data},
                head_word.lane_en);
        end
    end

    // ==========================================================
    // pins: output gate is asynchronous, so the enable is the one
    // output not straight from a flop
    assign data_oe_n = ~drive_q | output_gate_n;
    assign data_out = rd_cell_q[`SSC_DATA_W-1:0];
    assign parity_lines_out = rd_cell_q[CELL_W-1:`SSC_DATA_W];

    // stall flag for observers, registered
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            queue_full_q <= 1'b0;
        end
        else
        begin
            queue_full_q <= ~q_in_ready;
        end
    end

endmodule : ssc_sram_ctrl

// ===== bench/ssc_ctl_model.sv
`timescale 1ns/1ns
`include "ssc_map.svh"

// ==========================================================
// memory controller model on the shared data pins
module ssc_ctl_model (
    // clock
    input wire logic clk_sys,
    // controls toward the memory
    output logic chip_select_a_n,
    output logic chip_select_b,
    output logic chip_select_c_n,
    output logic clock_qualify_n,
    output logic [`SSC_ADDR_W-1:0] address,
    output logic write_n,
    output logic advance_or_load,
    output logic [`SSC_LANES-1:0] byte_lane_write_n,
    // resolved level of parity and data pins
    output logic [17:0] pins,
    // device side of the pins
    input wire logic [17:0] dev_pins,
    input wire logic data_oe_n
);
    logic drive_en = 1'b0;
    logic [17:0] wdata = 18'h0;
    logic [17:0] flt_q = 18'h2AAAA;

    // released lines toggle every cycle so a stale word never passes
    always @(posedge clk_sys)
        flt_q <= ~flt_q;
    assign pins = drive_en ? wdata : (!data_oe_n ? dev_pins : flt_q);

    // idle and deselected until the first cycle is issued
    initial
    begin
        {chip_select_a_n, chip_select_b, chip_select_c_n} = 3'b111;
        clock_qualify_n = 1'b1;
        address = 18'h0;
        write_n = 1'b1;
        advance_or_load = 1'b0;
        byte_lane_write_n = 2'h3;
    end

    // one bus cycle, applied at the falling edge, held to the next one
    // data is driven only in the write data phase
    task cyc(input logic [2:0] s, input logic w, v, q,
        input logic [17:0] a, input logic [1:0] ln, input logic d,
        input logic [17:0] x);
        @(negedge clk_sys);
        {chip_select_a_n, chip_select_b, chip_select_c_n} = s;
        write_n = w;
        advance_or_load = v;
        clock_qualify_n = q;
        address = a;
        byte_lane_write_n = ln;
        drive_en = d;
        wdata = x;
    endtask : cyc
endmodule : ssc_ctl_model

// ===== bench/ssc_sram_ctrl_monitor.sv
`timescale 1ns/1ns
`include "ssc_map.svh"

// ==========================================================
// pin protocol checker
module ssc_sram_ctrl_monitor (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // controls
    input wire logic chip_select_a_n,
    input wire logic chip_select_b,
    input wire logic chip_select_c_n,
    input wire logic clock_qualify_n,
    input wire logic write_n,
    input wire logic advance_or_load,
    input wire logic output_gate_n,
    // outputs
    input wire logic [`SSC_DATA_W-1:0] data_out,
    input wire logic [`SSC_LANES-1:0] parity_lines_out,
    input wire logic data_oe_n,
    input wire logic queue_full_q
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    // an edge that counts, a load, and a full select
    wire go = !clock_qualify_n && !queue_full_q;
    wire ld = go && !advance_or_load;
    wire sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;

    chk_gate_float: assert property (output_gate_n |-> data_oe_n)
        else $error("pins driven with gate high");
    chk_read_drive: assert property (
        (ld && sel && write_n) ##1 go |=> (output_gate_n || !data_oe_n))
        else $error("read data not driven one edge later");
    chk_no_select: assert property ((ld && !sel) ##1 go
        |=> data_oe_n)
        else $error("pins still driven after deselect");
    chk_write_float: assert property ((ld && sel && !write_n) ##1 go
        |=> data_oe_n)
        else $error("pins driven in write data phase");
    chk_hold_data: assert property (clock_qualify_n
        |=> $stable(data_out))
        else $error("data changed on an ignored edge");
    chk_hold_parity: assert property (clock_qualify_n
        |=> $stable(parity_lines_out))
        else $error("parity changed on an ignored edge");
    chk_hold_drive: assert property ((clock_qualify_n && !output_gate_n)
        ##1 !output_gate_n |-> $stable(data_oe_n))
        else $error("drive changed on an ignored edge");
    chk_reset_idle: assert property (disable iff (1'b0) !reset_n
        |=> data_oe_n && data_out == 16'h0)
        else $error("outputs not idle after reset");

    cover property (ld && sel && write_n);
    cover property (ld && sel && !write_n);
    cover property (clock_qualify_n && !data_oe_n);
endmodule : ssc_sram_ctrl_monitor

bind ssc_sram_ctrl ssc_sram_ctrl_monitor mon (.clk_sys, .reset_n,
    .chip_select_a_n, .chip_select_b, .chip_select_c_n, .clock_qualify_n,
    .write_n, .advance_or_load, .output_gate_n, .data_out,
    .parity_lines_out, .data_oe_n, .queue_full_q);

// ===== bench/ssc_sram_ctrl_test.sv
`timescale 1ns/1ns
`include "ssc_map.svh"

// ==========================================================
// bench top
module ssc_sram_ctrl_test;
    localparam logic [17:0] X1 = 18'h3A55C;
    localparam logic [17:0] X2 = 18'h11234;
    localparam logic [17:0] MIX = {X1[17], X2[16], X1[15:8], X2[7:0]};
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic output_gate_n = 1'b0;
    logic burst_mode_strap = 1'b1;
    logic chip_select_a_n, chip_select_b, chip_select_c_n, clock_qualify_n;
    logic write_n, advance_or_load, data_oe_n, queue_full_q;
    logic [`SSC_ADDR_W-1:0] address;
    logic [`SSC_LANES-1:0] byte_lane_write_n, parity_lines_in;
    logic [`SSC_LANES-1:0] parity_lines_out;
    logic [`SSC_DATA_W-1:0] data_in, data_out;
    logic [17:0] pins;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    assign {parity_lines_in, data_in} = pins;
    ssc_sram_ctrl dut (.clk_sys, .reset_n, .chip_select_a_n, .chip_select_b,
        .chip_select_c_n, .clock_qualify_n, .address, .write_n,
        .advance_or_load, .byte_lane_write_n, .output_gate_n,
        .burst_mode_strap, .data_in, .data_out, .parity_lines_in,
        .parity_lines_out, .data_oe_n, .queue_full_q);
    ssc_ctl_model m (.clk_sys, .chip_select_a_n, .chip_select_b,
        .chip_select_c_n, .clock_qualify_n, .address, .write_n,
        .advance_or_load, .byte_lane_write_n, .pins,
        .dev_pins({parity_lines_out, data_out}), .data_oe_n);

    initial
        forever #10 clk_sys = ~clk_sys;

    // hang guard, far above the roughly 130 cycles the run needs
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            num_errors = num_errors + 1;
            end_of_test();
        end
    end

    task end_of_test;
        $display("checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    task chk(input logic [17:0] seen, input logic [17:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    function logic [17:0] wv(input logic [1:0] i);
        return {i, 8'h5A, 6'h0, i};
    endfunction : wv

    task idl(input logic q, input logic [1:0] ln);
        m.cyc(3'b111, 1'b1, 1'b0, q, 18'h0, ln, 1'b0, 18'h0);
    endtask : idl

    // strap moves only while reset holds the memory still
    task do_reset(input logic s);
        @(negedge clk_sys);
        reset_n = 1'b0;
        burst_mode_strap = s;
        repeat (10) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (2) idl(1'b0, 2'h3);
    endtask : do_reset

    task wr(input logic [17:0] a, input logic [1:0] ln, input logic [17:0] x);
        m.cyc(3'b010, 1'b0, 1'b0, 1'b0, a, ln, 1'b0, 18'h0);
        idl(1'b0, ln);
        m.cyc(3'b111, 1'b1, 1'b0, 1'b0, 18'h0, ln, 1'b1, x);
        idl(1'b0, ln);
    endtask : wr

    task rdchk(input logic [17:0] a, input logic [17:0] x);
        m.cyc(3'b010, 1'b1, 1'b0, 1'b0, a, 2'h3, 1'b0, 18'h0);
        idl(1'b0, 2'h3);
        idl(1'b0, 2'h3);
        chk({parity_lines_out, data_out}, x);
        chk(data_oe_n, 1'b0);
        idl(1'b0, 2'h3);
        chk(data_oe_n, 1'b1);
    endtask : rdchk

    task t_rw;
        wr(18'h00010, 2'h0, X1);
        rdchk(18'h00010, X1);
        wr(18'h00010, 2'h2, X2);
        rdchk(18'h00010, MIX);
        chk(queue_full_q, 1'b0);
        $display("write and read test done");
    endtask : t_rw

    // read then write back to back: the bus turns round cleanly
    task t_turn;
        m.cyc(3'b010, 1'b1, 1'b0, 1'b0, 18'h00010, 2'h3, 1'b0, 18'h0);
        m.cyc(3'b010, 1'b0, 1'b0, 1'b0, 18'h00020, 2'h0, 1'b0, 18'h0);
        idl(1'b0, 2'h0);
        chk({parity_lines_out, data_out}, MIX);
        m.cyc(3'b111, 1'b1, 1'b0, 1'b0, 18'h0, 2'h0, 1'b1, 18'h2BEEF);
        chk(data_oe_n, 1'b1);
        idl(1'b0, 2'h0);
        rdchk(18'h00020, 18'h2BEEF);
        $display("turn round test done");
    endtask : t_turn

    task t_sel;
        for (int s = 0; s < 8; s++)
        begin
            m.cyc(3'(s), 1'b1, 1'b0, 1'b0, 18'h00010, 2'h3, 1'b0, 18'h0);
            idl(1'b0, 2'h3);
            idl(1'b0, 2'h3);
            chk(data_oe_n, 18'(s != 2));
        end
        $display("chip select test done");
    endtask : t_sel

    task t_stall;
        m.cyc(3'b010, 1'b1, 1'b0, 1'b0, 18'h00020, 2'h3, 1'b0, 18'h0);
        idl(1'b1, 2'h3);
        idl(1'b1, 2'h3);
        chk(data_oe_n, 1'b1);
        idl(1'b0, 2'h3);
        idl(1'b1, 2'h3);
        chk({parity_lines_out, data_out}, 18'h2BEEF);
        output_gate_n = 1'b1;
        #1;
        chk(data_oe_n, 1'b1);
        idl(1'b1, 2'h3);
        output_gate_n = 1'b0;
        #1;
        chk(data_oe_n, 1'b0);
        idl(1'b1, 2'h3);
        chk(data_oe_n, 1'b0);
        idl(1'b0, 2'h3);
        idl(1'b0, 2'h3);
        chk(data_oe_n, 1'b1);
        $display("clock qualify test done");
    endtask : t_stall

    // strap high stands for an open pin, which reads as high
    task t_burst(input logic s);
        logic [1:0] k2;
        for (int i = 0; i < 4; i++)
            wr(18'(i), 2'h0, wv(2'(i)));
        m.cyc(3'b010, 1'b1, 1'b0, 1'b0, 18'h00001, 2'h3, 1'b0, 18'h0);
        m.cyc(3'b010, 1'b1, 1'b1, 1'b0, 18'h0, 2'h3, 1'b0, 18'h0);
        for (int k = 0; k < 4; k++)
        begin
            m.cyc(k < 2 ? 3'b010 : 3'b111, 1'b1, 1'(k < 2), 1'b0, 18'h0,
                2'h3, 1'b0, 18'h0);
            k2 = s ? 2'(1 ^ k) : 2'(1 + k);
            chk({parity_lines_out, data_out}, wv(k2));
        end
        $display("burst order test done, strap %b", s);
    endtask : t_burst

    initial
    begin
        do_reset(1'b1);
        t_rw();
        t_turn();
        t_sel();
        t_stall();
        t_burst(1'b1);
        do_reset(1'b0);
        t_burst(1'b0);
        end_of_test();
    end
endmodule : ssc_sram_ctrl_test
